/* hmf_pkg.sv */
// Shared constants and types for the host MAC receive address filter.
package hmf_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [5:0] IDX_CTRL = 6'h01;
  localparam logic [5:0] IDX_ADDRH = 6'h02;
  localparam logic [5:0] IDX_ADDRL = 6'h03;
  localparam logic [5:0] IDX_HASHH = 6'h04;
  localparam logic [5:0] IDX_HASHL = 6'h05;
  localparam logic [5:0] IDX_STAT = 6'h09;

  // Control register fields and reset values.
  localparam int RX_ENABLE_BIT = 2;
  localparam int PASS_ALL_BIT = 19;
  localparam logic [31:0] CTRL_MASK = 32'h00080004;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [15:0] ADDRH_RST = 16'hFFFF;
  localparam logic [31:0] ADDRL_RST = 32'h0FFFFFFF;
  localparam logic [31:0] HASH_RST = 32'h00000000;

  // Status register fields.
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_ACC_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;

  // Loader byte addresses that feed the station address.
  localparam logic [7:0] EE_ADDRL_B0 = 8'h01;
  localparam logic [7:0] EE_ADDRL_B1 = 8'h02;
  localparam logic [7:0] EE_ADDRL_B2 = 8'h03;
  localparam logic [7:0] EE_ADDRL_B3 = 8'h04;
  localparam logic [7:0] EE_ADDRH_B0 = 8'h05;
  localparam logic [7:0] EE_ADDRH_B1 = 8'h06;

  // Hash engine constants.
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [2:0] CRC_FIRST = 3'h1;
  localparam logic [2:0] CRC_LAST = 3'h5;

  // One byte written by the power-on loader.
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } hmf_ee_wr_t;

  // One frame offered by the switch fabric; da[7:0] is the first byte on the wire.
  typedef struct packed {
    logic valid;
    logic [47:0] da;
  } hmf_frame_t;

  typedef enum logic {HMF_IDLE, HMF_HASH} hmf_state_t;

endpackage

/* hmf_crc.sv */
// Byte-serial CRC-32 engine that yields the six-bit group hash index.
module hmf_crc (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic [47:0] da_in,
  output logic done_out,
  output logic [5:0] index_out
);

  logic [31:0] crc, next_crc;
  logic [39:0] rest, next_rest;
  logic [2:0] cnt, next_cnt;
  logic busy, next_busy;
  logic done, next_done;

  // Folds one byte into the CRC, least significant bit first as on the wire.
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      fb = r[31] ^ b[i];
      r = {r[30:0], 1'b0};
      if (fb)
      begin
        r = r ^ hmf_pkg::CRC_POLY;
      end
    end
    return r;
  endfunction

  // One byte per cycle; six bytes take six edges from the start.
  always_comb
  begin
    next_crc = crc;
    next_rest = rest;
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    if (start_in)
    begin
      next_crc = crc_byte(hmf_pkg::CRC_INIT, da_in[7:0]);
      next_rest = da_in[47:8];
      next_cnt = hmf_pkg::CRC_FIRST;
      next_busy = 1'b1;
    end
    else if (busy)
    begin
      next_crc = crc_byte(crc, rest[7:0]);
      next_rest = {8'h00, rest[39:8]};
      next_cnt = cnt + 3'h1;
      next_busy = (cnt != hmf_pkg::CRC_LAST);
      next_done = (cnt == hmf_pkg::CRC_LAST);
    end
  end

  // Engine state registers.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      crc <= 32'h00000000;
      rest <= 40'h0000000000;
      cnt <= 3'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      crc <= next_crc;
      rest <= next_rest;
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end

  // The index is the top six CRC bits and is meaningful while done is high.
  assign done_out = done;
  assign index_out = crc[31:26];

endmodule

/* hmf_decide.sv */
// Accept or reject decision for one destination address.
module hmf_decide (
  input wire logic [47:0] da_in,
  input wire logic [47:0] station_in,
  input wire logic [63:0] table_in,
  input wire logic [5:0] index_in,
  input wire logic pass_all_in,
  output logic accept_out
);

  // Individual addresses must match the station; broadcast always passes.
  always_comb
  begin
    if (!da_in[0])
    begin
      accept_out = (da_in == station_in);
    end
    else if (&da_in)
    begin
      accept_out = 1'b1;
    end
    else
    begin
      accept_out = pass_all_in | table_in[index_in];
    end
  end

endmodule

/* hmf_filter.sv */
// Host MAC receive address filter with APB registers and loader fill.
// Overview of operation
// - Receive enable bit set lets frames in; clear means no frame is taken.
// - Loader byte 05h fills address high bits 7:0, byte 06h bits 15:8.
// - Loader bytes 01h to 04h fill address low, 01h lowest, 04h highest.
// - Address is undefined until load ends; host writes only after that.
// - High register holds address 47:32 in 15:0; bits 31:16 read zero.
// - 64-bit hash table; index top bit picks register, rest picks bit.
// - Index 000000 picks low bit 0; 111111 picks high bit 31.
// - Multicast frame accepted when selected table bit is one, else rejected.
// - Pass all multicast bit accepts every multicast frame regardless of table.
// - Table only judges frames the fabric already delivered to this MAC.
// - Upper and lower hash registers hold table halves, reset to zero.
module hmf_filter (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire hmf_pkg::hmf_ee_wr_t EE_WR_IN,
  input wire logic EE_DONE_IN,
  input wire hmf_pkg::hmf_frame_t FRAME_IN,
  output logic FRAME_READY_OUT,
  output logic RX_VALID_OUT,
  output logic RX_ACCEPT_OUT
);

  logic [31:0] ctrl, next_ctrl;
  logic [15:0] addr_hi, next_addr_hi;
  logic [31:0] addr_lo, next_addr_lo;
  logic [31:0] hash_hi, next_hash_hi;
  logic [31:0] hash_lo, next_hash_lo;
  logic load_done, next_load_done;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  hmf_pkg::hmf_state_t state, next_state;
  logic [47:0] da_q, next_da_q;
  logic next_ready, next_rx_valid, next_rx_accept;
  logic last_accept, next_last_accept;
  logic [5:0] sel;
  logic setup, wr, take, crc_done, accept;
  logic [5:0] crc_index;
  logic [31:0] rd_data;
  logic mapped;

  // Merges write data into an old value under the APB byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Bus decode; addresses above the register window are unmapped.
  assign sel = PADDR_IN[7:2];
  assign setup = PSEL_IN & ~PENABLE_IN;
  assign wr = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT;
  assign take = FRAME_IN.valid & FRAME_READY_OUT;

  // Read mux; the high address register returns zero above bit 15.
  always_comb
  begin
    mapped = 1'b1;
    case (sel)
      hmf_pkg::IDX_CTRL: rd_data = ctrl;
      hmf_pkg::IDX_ADDRH: rd_data = {16'h0000, addr_hi};
      hmf_pkg::IDX_ADDRL: rd_data = addr_lo;
      hmf_pkg::IDX_HASHH: rd_data = hash_hi;
      hmf_pkg::IDX_HASHL: rd_data = hash_lo;
      hmf_pkg::IDX_STAT:
      begin
        rd_data = 32'h00000000;
        rd_data[hmf_pkg::STAT_DONE_BIT] = load_done;
        rd_data[hmf_pkg::STAT_ACC_BIT] = last_accept;
        rd_data[hmf_pkg::STAT_BUSY_BIT] = (state == hmf_pkg::HMF_HASH);
      end
      default:
      begin
        rd_data = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
  end

  // APB answer: ready and data are registered in the setup cycle, so every
  // access completes in its first access cycle.
  always_comb
  begin
    next_pready = setup;
    next_prdata = setup ? rd_data : 32'h00000000;
    next_pslverr = setup & ~mapped;
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h00000000;
      PSLVERR_OUT <= 1'b0;
    end
    else
    begin
      PREADY_OUT <= next_pready;
      PRDATA_OUT <= next_prdata;
      PSLVERR_OUT <= next_pslverr;
    end
  end

  // Register file. The loader owns the station address until it reports
  // completion; host writes before that are dropped so the fill is not torn.
  always_comb
  begin
    next_ctrl = ctrl;
    next_addr_hi = addr_hi;
    next_addr_lo = addr_lo;
    next_hash_hi = hash_hi;
    next_hash_lo = hash_lo;
    next_load_done = load_done | EE_DONE_IN;
    if (wr)
    begin
      case (sel)
        hmf_pkg::IDX_CTRL: next_ctrl = merge(ctrl, PWDATA_IN, PSTRB_IN) & hmf_pkg::CTRL_MASK;
        hmf_pkg::IDX_ADDRH:
        begin
          if (load_done)
          begin
            next_addr_hi = 16'(merge({16'h0000, addr_hi}, PWDATA_IN, PSTRB_IN));
          end
        end
        hmf_pkg::IDX_ADDRL:
        begin
          if (load_done)
          begin
            next_addr_lo = merge(addr_lo, PWDATA_IN, PSTRB_IN);
          end
        end
        hmf_pkg::IDX_HASHH: next_hash_hi = merge(hash_hi, PWDATA_IN, PSTRB_IN);
        hmf_pkg::IDX_HASHL: next_hash_lo = merge(hash_lo, PWDATA_IN, PSTRB_IN);
        default: next_ctrl = ctrl;
      endcase
    end
    if (EE_WR_IN.valid & ~load_done)
    begin
      case (EE_WR_IN.addr)
        hmf_pkg::EE_ADDRL_B0: next_addr_lo[7:0] = EE_WR_IN.data;
        hmf_pkg::EE_ADDRL_B1: next_addr_lo[15:8] = EE_WR_IN.data;
        hmf_pkg::EE_ADDRL_B2: next_addr_lo[23:16] = EE_WR_IN.data;
        hmf_pkg::EE_ADDRL_B3: next_addr_lo[31:24] = EE_WR_IN.data;
        hmf_pkg::EE_ADDRH_B0: next_addr_hi[7:0] = EE_WR_IN.data;
        hmf_pkg::EE_ADDRH_B1: next_addr_hi[15:8] = EE_WR_IN.data;
        default: next_addr_hi = next_addr_hi;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      ctrl <= hmf_pkg::CTRL_RST;
      addr_hi <= hmf_pkg::ADDRH_RST;
      addr_lo <= hmf_pkg::ADDRL_RST;
      hash_hi <= hmf_pkg::HASH_RST;
      hash_lo <= hmf_pkg::HASH_RST;
      load_done <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      addr_hi <= next_addr_hi;
      addr_lo <= next_addr_lo;
      hash_hi <= next_hash_hi;
      hash_lo <= next_hash_lo;
      load_done <= next_load_done;
    end
  end

  // Hash engine and decision for the frame in flight.
  hmf_crc u_crc (
    .clk_in(CLK_IN),
    .rstn_in(RESETN_IN),
    .start_in(take),
    .da_in(FRAME_IN.da),
    .done_out(crc_done),
    .index_out(crc_index)
  );

  hmf_decide u_decide (
    .da_in(da_q),
    .station_in({addr_hi, addr_lo}),
    .table_in({hash_hi, hash_lo}),
    .index_in(crc_index),
    .pass_all_in(ctrl[hmf_pkg::PASS_ALL_BIT]),
    .accept_out(accept)
  );

  // Frame intake. Only frames the fabric offers are judged; the fabric alone
  // decides what is offered. A frame already taken finishes even if the
  // receiver is disabled meanwhile.
  always_comb
  begin
    next_state = state;
    next_da_q = da_q;
    next_rx_valid = 1'b0;
    next_rx_accept = 1'b0;
    next_last_accept = last_accept;
    case (state)
      hmf_pkg::HMF_IDLE:
      begin
        if (take)
        begin
          next_state = hmf_pkg::HMF_HASH;
          next_da_q = FRAME_IN.da;
        end
      end
      hmf_pkg::HMF_HASH:
      begin
        if (crc_done)
        begin
          next_state = hmf_pkg::HMF_IDLE;
          next_rx_valid = 1'b1;
          next_rx_accept = accept;
          next_last_accept = accept;
        end
      end
      default: next_state = hmf_pkg::HMF_IDLE;
    endcase
    next_ready = (next_state == hmf_pkg::HMF_IDLE) & next_ctrl[hmf_pkg::RX_ENABLE_BIT];
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      state <= hmf_pkg::HMF_IDLE;
      da_q <= 48'h000000000000;
      FRAME_READY_OUT <= 1'b0;
      RX_VALID_OUT <= 1'b0;
      RX_ACCEPT_OUT <= 1'b0;
      last_accept <= 1'b0;
    end
    else
    begin
      state <= next_state;
      da_q <= next_da_q;
      FRAME_READY_OUT <= next_ready;
      RX_VALID_OUT <= next_rx_valid;
      RX_ACCEPT_OUT <= next_rx_accept;
      last_accept <= next_last_accept;
    end
  end

  // Helper terms that only the checks below read.
  logic chk_group, chk_bcast, chk_bit;
  logic [63:0] chk_table;
  assign chk_group = da_q[0];
  assign chk_bcast = &da_q;
  assign chk_table = {hash_hi, hash_lo};
  assign chk_bit = chk_table[crc_index];

  sequence s_take;
    take;
  endsequence

  sequence s_verdict;
    ##7 RX_VALID_OUT;
  endsequence

  property p_rx_off;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    !ctrl[hmf_pkg::RX_ENABLE_BIT] |-> !FRAME_READY_OUT;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("Frame intake open while receiver disabled.");

  property p_latency;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    s_take |=> (!FRAME_READY_OUT [*6]) ##1 RX_VALID_OUT;
  endproperty
  a_latency: assert property (p_latency) else $error("Verdict not seven edges after intake.");

  property p_ee_high;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    EE_WR_IN.valid && !load_done && EE_WR_IN.addr == hmf_pkg::EE_ADDRH_B1 |=> addr_hi[15:8] == $past(EE_WR_IN.data);
  endproperty
  a_ee_high: assert property (p_ee_high) else $error("Loader byte missed address high.");

  property p_ee_low;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    EE_WR_IN.valid && !load_done && EE_WR_IN.addr == hmf_pkg::EE_ADDRL_B0 |=> addr_lo[7:0] == $past(EE_WR_IN.data);
  endproperty
  a_ee_low: assert property (p_ee_low) else $error("Loader byte missed address low.");

  property p_locked;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    wr && !load_done && sel == hmf_pkg::IDX_ADDRL && !EE_WR_IN.valid |=> $stable(addr_lo);
  endproperty
  a_locked: assert property (p_locked) else $error("Host changed address before load done.");

  property p_resv;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    setup && sel == hmf_pkg::IDX_ADDRH |=> PREADY_OUT && PRDATA_OUT[31:16] == 16'h0000;
  endproperty
  a_resv: assert property (p_resv) else $error("Reserved address bits read nonzero.");

  property p_hash_bit;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    state == hmf_pkg::HMF_HASH && crc_done && chk_group && !chk_bcast && !ctrl[hmf_pkg::PASS_ALL_BIT]
      |=> RX_VALID_OUT && RX_ACCEPT_OUT == $past(chk_bit);
  endproperty
  a_hash_bit: assert property (p_hash_bit) else $error("Multicast verdict disagrees with table.");

  property p_pass_all;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    state == hmf_pkg::HMF_HASH && crc_done && chk_group && ctrl[hmf_pkg::PASS_ALL_BIT] |=> RX_ACCEPT_OUT;
  endproperty
  a_pass_all: assert property (p_pass_all) else $error("Multicast rejected with pass all set.");

endmodule

/* hmf_fabric_model.sv */
// Switch fabric model that offers destination addresses to the host MAC filter.
module hmf_fabric_model (
  input wire logic clk_in,
  input wire logic frame_ready_in,
  output hmf_pkg::hmf_frame_t frame_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Nothing is offered until a test asks for it.
  initial frame_out = {1'b0, 48'hA5A5A5A5A5A5};

  // Offers one address after a stall and holds it for up to 12 edges until the filter takes it.
  // The fabric alone decides what reaches the MAC, so a refused offer is simply dropped.
  task automatic offer(input logic [47:0] da, input int stall, output logic taken);
    int n;
    taken = 1'b0;
    repeat (stall) @(posedge clk_in);
    frame_out <= {1'b1, da};
    for (n = 0; n < 12 && !taken; n++)
    begin
      @(posedge clk_in);
      taken = (frame_ready_in === 1'b1);
    end
    // Released lines carry the inverted address, so stale data never matches by luck.
    frame_out <= {1'b0, ~da};
  endtask
endmodule

/* tb.sv */
// Self-checking bench for the host MAC receive address filter.
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  hmf_pkg::hmf_ee_wr_t ee_wr = '0;
  logic ee_done = 1'b0;
  hmf_pkg::hmf_frame_t frame;
  logic frame_ready;
  logic rx_valid;
  logic rx_accept;
  int error_cnt = 0;
  int n_tests = 0;
  logic [47:0] das [4] = '{48'h000000000001, 48'h00005E000001, 48'h123456789A01, 48'hFFFFFFFFFF33};

  // Half period of 25 ns gives the 20 MHz clock.
  always #25 clk = ~clk;

  hmf_filter dut (.CLK_IN(clk), .RESETN_IN(resetn), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(4'hF),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EE_WR_IN(ee_wr),
    .EE_DONE_IN(ee_done), .FRAME_IN(frame), .FRAME_READY_OUT(frame_ready),
    .RX_VALID_OUT(rx_valid), .RX_ACCEPT_OUT(rx_accept));

  hmf_fabric_model fab (.clk_in(clk), .frame_ready_in(frame_ready), .frame_out(frame));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tmo(input string what);
    error_cnt++;
    $display("CHECK FAILED at %0t: timeout %s", $time, what);
    tally_and_finish();
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk32({31'h0, got}, {31'h0, exp}, what);
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 8; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (pready !== 1'b1)
      tmo("apb");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h00000000, r, e);
    chk32(r, exp, "read data");
    chk1(e, 1'b0, "read error");
  endtask

  task automatic ee(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    ee_wr <= {1'b1, a, d};
    @(posedge clk);
    ee_wr <= '0;
  endtask

  // Offers a frame and checks the single verdict that follows.
  task automatic frame_chk(input logic [47:0] da, input logic exp);
    logic taken;
    int n;
    fab.offer(da, 1, taken);
    if (taken !== 1'b1)
      tmo("frame intake");
    for (n = 0; n < 12 && rx_valid !== 1'b1; n++)
      @(posedge clk);
    if (rx_valid !== 1'b1)
      tmo("verdict");
    chk1(rx_accept, exp, "verdict");
  endtask

  // Independent hash: CRC-32 over the address, first byte and LSB first, top six bits.
  function automatic logic [5:0] hash_idx(input logic [47:0] da);
    logic [31:0] c;
    int i;
    c = hmf_pkg::CRC_INIT;
    for (i = 0; i < 48; i++)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? hmf_pkg::CRC_POLY : 32'h00000000);
    return c[31:26];
  endfunction

  // A hang anywhere ends the run through the closing report.
  initial
  begin
    repeat (20000) @(posedge clk);
    tmo("watchdog");
  end

  initial
  begin
    logic taken;
    logic [31:0] r;
    logic e;
    logic [5:0] idx;
    logic [31:0] hh;
    logic [31:0] hl;
    logic [31:0] ctl;
    logic x;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(hmf_pkg::IDX_ADDRH, 32'h0000FFFF);
    rd_chk(hmf_pkg::IDX_HASHH, 32'h00000000);
    rd_chk(hmf_pkg::IDX_HASHL, 32'h00000000);
    rd_chk(hmf_pkg::IDX_CTRL, 32'h00000000);
    wr(hmf_pkg::IDX_ADDRL, 32'h12345678);
    rd_chk(hmf_pkg::IDX_ADDRL, hmf_pkg::ADDRL_RST);
    // Loader bytes 01h to 07h; the last one maps nowhere.
    for (int i = 0; i < 7; i++)
      ee(8'h01 + 8'(i), 8'h10 + 8'(2 * i));
    rd_chk(hmf_pkg::IDX_ADDRL, 32'h16141210);
    rd_chk(hmf_pkg::IDX_ADDRH, 32'h00001A18);
    @(posedge clk);
    ee_done <= 1'b1;
    @(posedge clk);
    ee_done <= 1'b0;
    ee(hmf_pkg::EE_ADDRH_B0, 8'hEE);
    rd_chk(hmf_pkg::IDX_ADDRH, 32'h00001A18);
    wr(hmf_pkg::IDX_ADDRH, 32'hFFFF0246);
    rd_chk(hmf_pkg::IDX_ADDRH, 32'h00000246);
    wr(hmf_pkg::IDX_ADDRL, 32'h8ACE0000);
    rd_chk(hmf_pkg::IDX_ADDRL, 32'h8ACE0000);
    apb(1'b0, 6'h3F, 32'h00000000, r, e);
    chk1(e, 1'b1, "unmapped error");
    chk32(r, 32'h00000000, "unmapped data");
    // Receiver off: an offer must not be taken and no verdict appears.
    fab.offer(das[1], 0, taken);
    chk1(taken, 1'b0, "taken while off");
    chk1(rx_valid, 1'b0, "verdict while off");
    wr(hmf_pkg::IDX_CTRL, 32'h1 << hmf_pkg::RX_ENABLE_BIT);
    repeat (2) @(posedge clk);
    chk1(frame_ready, 1'b1, "intake open");
    // Each address against six table setups: empty, low half, high half, own bit, pass all, neighbour bit.
    foreach (das[k])
      for (int m = 0; m < 6; m++)
      begin
        idx = hash_idx(das[k]);
        hh = 32'h00000000;
        hl = 32'h00000000;
        ctl = 32'h1 << hmf_pkg::RX_ENABLE_BIT;
        x = (m == 3 || m == 4);
        if (m == 1)
          hl = 32'hFFFFFFFF;
        if (m == 2)
          hh = 32'hFFFFFFFF;
        if (m == 1 || m == 2)
          x = (idx[5] == (m == 2));
        if (m == 3 || m == 5)
          {hh, hl} = 64'h1 << (m == 3 ? idx : idx ^ 6'h01);
        if (m == 4)
          ctl = ctl | (32'h1 << hmf_pkg::PASS_ALL_BIT);
        wr(hmf_pkg::IDX_HASHH, hh);
        wr(hmf_pkg::IDX_HASHL, hl);
        wr(hmf_pkg::IDX_CTRL, ctl);
        rd_chk(hmf_pkg::IDX_HASHL, hl);
        frame_chk(das[k], x);
      end
    // Station address match, a near miss, and broadcast with only the last neighbour bit left in the table.
    frame_chk(48'h02468ACE0000, 1'b1);
    frame_chk(48'h02468ACE0002, 1'b0);
    frame_chk(48'hFFFFFFFFFFFF, 1'b1);
    // Status: load finished, last verdict accepted, engine idle.
    rd_chk(hmf_pkg::IDX_STAT, 32'h00000003);
    // Reset in mid-run closes intake and clears the table again.
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    chk1(frame_ready, 1'b0, "intake after reset");
    resetn <= 1'b1;
    rd_chk(hmf_pkg::IDX_HASHH, 32'h00000000);
    rd_chk(hmf_pkg::IDX_CTRL, 32'h00000000);
    tally_and_finish();
  end
endmodule
